// ==== pcs_pkg.sv ====
// Constants and types for the program counter sequencer
// Operation
// RL1 - Binary counter, width 10 or 11 bits
// RL2 - Counter value is program memory word address
// RL3 - Advance by one per executed instruction
// RL4 - Reset clears counter to word zero
// RL5 - Load only on reset, branch, call, return, interrupt; the code also loads on table read
// RL6 - Direct jump/call loads target from instruction
// RL7 - Indirect jump/call/table read load address register
// RL8 - Returns load address stack top entry
// RL9 - Accepted interrupt loads its vector address
// RL10 - Call or table read saves return address first
// RL11 - Increment wraps from all ones to zero
package pcs_pkg;

	// ==========================================
	// Widths and sizes
	localparam int PCS_WIDTH_SMALL = 10;
	localparam int PCS_WIDTH_LARGE = 11;
	localparam int PCS_WORDS_SMALL = 1024;
	localparam int PCS_WORDS_LARGE = 2048;
	localparam int PCS_INSTR_WIDTH = 16;
	localparam int PCS_OP_WIDTH = 4;
	localparam logic [10:0] PCS_RESET_ADDR = 11'h000;
	localparam logic [10:0] PCS_VECTOR_LAST = 11'h005;

	// ==========================================
	// Sequencing operations
	typedef enum logic [3:0] {
		PCS_OP_NEXT,
		PCS_OP_JUMP,
		PCS_OP_CALL,
		PCS_OP_JUMP_IND,
		PCS_OP_CALL_IND,
		PCS_OP_TABLE_READ,
		PCS_OP_RETURN,
		PCS_OP_RETURN_SKIP,
		PCS_OP_RETURN_IRQ
	} pcs_op_t;

	typedef enum logic [1:0] {
		PCS_SRC_INC,
		PCS_SRC_DIRECT,
		PCS_SRC_REG,
		PCS_SRC_STACK
	} pcs_src_t;

endpackage : pcs_pkg

// ==== pcs_decode.sv ====
// Operation decoder choosing next address source
`timescale 1ns/1ns
module pcs_decode
	import pcs_pkg::*;
(
	input wire pcs_op_t op_in,
	output pcs_src_t src_out,
	output logic push_out,
	output logic table_out
);

	// ==========================================
	// Source selection
	always_comb
	begin
		src_out = PCS_SRC_INC;
		push_out = 1'b0;
		table_out = 1'b0;
		case (op_in)
			PCS_OP_JUMP: src_out = PCS_SRC_DIRECT; // RL6
			PCS_OP_CALL:
			begin
				src_out = PCS_SRC_DIRECT; // RL6
				push_out = 1'b1; // RL10
			end
			PCS_OP_JUMP_IND: src_out = PCS_SRC_REG; // RL7
			PCS_OP_CALL_IND:
			begin
				src_out = PCS_SRC_REG; // RL7
				push_out = 1'b1; // RL10
			end
			PCS_OP_TABLE_READ:
			begin
				src_out = PCS_SRC_REG; // RL7
				push_out = 1'b1; // RL10
				table_out = 1'b1;
			end
			PCS_OP_RETURN,
			PCS_OP_RETURN_SKIP,
			PCS_OP_RETURN_IRQ: src_out = PCS_SRC_STACK; // RL8
			default: src_out = PCS_SRC_INC;
		endcase
	end

endmodule : pcs_decode

// ==== pcs_program_counter.sv ====
// Program counter and next-address sequencer
`timescale 1ns/1ns
module pcs_program_counter
	import pcs_pkg::*;
#(
	parameter int PC_WIDTH = PCS_WIDTH_LARGE
)
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic exec_in,
	input wire pcs_op_t op_in,
	input wire logic [PC_WIDTH-1:0] target_addr_in,
	input wire logic [PC_WIDTH-1:0] jump_target_reg_in,
	input wire logic [PC_WIDTH-1:0] stack_top_in,
	input wire logic irq_accept_in,
	input wire logic [PC_WIDTH-1:0] irq_vector_in,
	output logic [PC_WIDTH-1:0] instr_pointer_out,
	output logic stack_push_out,
	output logic [PC_WIDTH-1:0] stack_push_addr_out,
	output logic stack_pop_out,
	output logic table_fetch_out,
	output logic [PC_WIDTH-1:0] return_addr_out
);

	// ==========================================
	// Parameter check
	localparam int PC_WORDS = 1 << PC_WIDTH; // RL2
	localparam logic [PC_WIDTH-1:0] PC_RESET =
		PCS_RESET_ADDR[PC_WIDTH-1:0]; // RL4

	if (PC_WIDTH != PCS_WIDTH_SMALL && PC_WIDTH != PCS_WIDTH_LARGE)
	begin : g_bad_width
		$error("pcs_program_counter: PC_WIDTH must be 10 or 11");
	end

	if (PC_WORDS != PCS_WORDS_SMALL && PC_WORDS != PCS_WORDS_LARGE)
	begin : g_bad_words
		$error("pcs_program_counter: memory must be 1024 or 2048 words");
	end

	// ==========================================
	// Internal signals
	pcs_src_t src;
	logic push;
	logic table_rd;
	logic take_irq;
	logic take_exec;
	logic push_exec;
	logic pop_exec;
	logic table_exec;
	logic [PC_WIDTH-1:0] instr_pointer_r;
	logic [PC_WIDTH-1:0] instr_pointer_nxt;
	logic [PC_WIDTH-1:0] pc_inc;
	logic [PC_WIDTH-1:0] carry;
	logic [PC_WIDTH-1:0] push_addr_nxt;

	// ==========================================
	// Decode
	pcs_decode u_decode (
		.op_in(op_in),
		.src_out(src),
		.push_out(push),
		.table_out(table_rd)
	);

	// ==========================================
	// Request qualifiers
	assign take_irq = irq_accept_in; // RL9
	assign take_exec = exec_in && !irq_accept_in; // RL5
	assign push_exec = take_exec && push; // RL10
	assign pop_exec = take_exec && src == PCS_SRC_STACK; // RL8
	assign table_exec = take_exec && table_rd; // RL7

	// ==========================================
	// Incrementer, carry dropped at the top bit
	assign carry[0] = 1'b1;

	for (genvar gi = 0; gi < PC_WIDTH; gi++)
	begin : g_inc
		assign pc_inc[gi] = instr_pointer_r[gi] ^ carry[gi]; // RL1 RL3
		if (gi < PC_WIDTH - 1)
		begin : g_carry
			assign carry[gi+1] = instr_pointer_r[gi] & carry[gi]; // RL11
		end
	end

	// ==========================================
	// Next address
	always_comb
	begin
		instr_pointer_nxt = instr_pointer_r;
		if (take_irq)
		begin
			instr_pointer_nxt = irq_vector_in; // RL9
		end
		else if (take_exec)
		begin
			case (src)
				PCS_SRC_DIRECT:
				begin
					instr_pointer_nxt = target_addr_in; // RL6
				end
				PCS_SRC_REG:
				begin
					instr_pointer_nxt = jump_target_reg_in; // RL7
				end
				PCS_SRC_STACK:
				begin
					instr_pointer_nxt = stack_top_in; // RL8
				end
				default:
				begin
					instr_pointer_nxt = pc_inc; // RL3 RL5
				end
			endcase
		end
	end

	// ==========================================
	// Push address select
	always_comb
	begin
		if (take_irq)
		begin
			push_addr_nxt = instr_pointer_r; // RL10
		end
		else
		begin
			push_addr_nxt = pc_inc; // RL10
		end
	end

	// ==========================================
	// Counter register
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			instr_pointer_r <= PC_RESET; // RL4
		end
		else
		begin
			instr_pointer_r <= instr_pointer_nxt; // RL5
		end
	end

	// ==========================================
	// Push strobe
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			stack_push_out <= 1'b0;
		end
		else
		begin
			stack_push_out <= take_irq || push_exec; // RL10
		end
	end

	// ==========================================
	// Push address
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			stack_push_addr_out <= '0;
		end
		else
		begin
			stack_push_addr_out <= push_addr_nxt; // RL10
		end
	end

	// ==========================================
	// Pop strobe
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			stack_pop_out <= 1'b0;
		end
		else
		begin
			stack_pop_out <= pop_exec; // RL8
		end
	end

	// ==========================================
	// Table fetch strobe
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			table_fetch_out <= 1'b0;
		end
		else
		begin
			table_fetch_out <= table_exec; // RL7
		end
	end

	// ==========================================
	// Return address
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			return_addr_out <= '0;
		end
		else
		begin
			return_addr_out <= pc_inc; // RL10
		end
	end

	// ==========================================
	// Output
	assign instr_pointer_out = instr_pointer_r; // RL2

endmodule : pcs_program_counter

// ==== pcs_partner.sv ====
// Behavioural one-entry address store beside the sequencer, loaded on each push; pops leave it unchanged
`timescale 1ns/1ns
module pcs_partner
(
	input wire logic mclk_in,
	input wire logic push_in,
	input wire logic [10:0] addr_in,
	output logic [10:0] top_out
);
	always_ff @(posedge mclk_in)
	begin
		if (push_in)
		begin
			top_out <= addr_in;
		end
	end
endmodule : pcs_partner

// ==== pcs_properties.sv ====
// Port assertions for the program counter sequencer
`timescale 1ns/1ns
module pcs_props
	import pcs_pkg::*;
#(parameter int PC_WIDTH = 11)
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic exec_in,
	input wire pcs_op_t op_in,
	input wire logic [PC_WIDTH-1:0] target_addr_in,
	input wire logic [PC_WIDTH-1:0] jump_target_reg_in,
	input wire logic [PC_WIDTH-1:0] stack_top_in,
	input wire logic irq_accept_in,
	input wire logic [PC_WIDTH-1:0] irq_vector_in,
	input wire logic [PC_WIDTH-1:0] instr_pointer_out,
	input wire logic stack_push_out,
	input wire logic stack_pop_out,
	input wire logic table_fetch_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	wire ex = exec_in && !irq_accept_in;
	property p_inc;
		ex && op_in == PCS_OP_NEXT |=>
		instr_pointer_out == $past(instr_pointer_out) + 1'b1;
	endproperty
	a_inc: assert property (p_inc) else $error("no step");
	property p_jmp;
		ex && op_in == PCS_OP_JUMP |=> instr_pointer_out == $past(target_addr_in);
	endproperty
	a_jmp: assert property (p_jmp) else $error("bad jump");
	property p_ind;
		ex && op_in inside {PCS_OP_JUMP_IND, PCS_OP_CALL_IND, PCS_OP_TABLE_READ}
		|=> instr_pointer_out == $past(jump_target_reg_in);
	endproperty
	a_ind: assert property (p_ind) else $error("bad indirect");
	property p_ret;
		ex && op_in inside {PCS_OP_RETURN, PCS_OP_RETURN_SKIP, PCS_OP_RETURN_IRQ}
		|=> stack_pop_out && instr_pointer_out == $past(stack_top_in);
	endproperty
	a_ret: assert property (p_ret) else $error("bad return");
	property p_irq;
		irq_accept_in |=> instr_pointer_out == $past(irq_vector_in);
	endproperty
	a_irq: assert property (p_irq) else $error("bad vector");
	property p_hold;
		!exec_in && !irq_accept_in |=> $stable(instr_pointer_out);
	endproperty
	a_hold: assert property (p_hold) else $error("idle move");
	property p_push;
		ex && op_in == PCS_OP_CALL |=> stack_push_out;
	endproperty
	a_push: assert property (p_push) else $error("no push");
	property p_tbl;
		ex && op_in == PCS_OP_TABLE_READ |=> table_fetch_out && stack_push_out;
	endproperty
	a_tbl: assert property (p_tbl) else $error("no table push");
	cover property (irq_accept_in);
	cover property (ex && op_in == PCS_OP_CALL);
	cover property (ex && op_in == PCS_OP_RETURN);
endmodule : pcs_props
bind pcs_program_counter pcs_props #(.PC_WIDTH(PC_WIDTH)) u_props (.*);

// ==== pcs_program_counter_bench.sv ====
// Self-checking bench for the program counter sequencer
`timescale 1ns/1ns
module pcs_program_counter_bench import pcs_pkg::*;;
	logic mclk_in = 0, rst_n_in = 0, exec_in = 0, irq_accept_in = 0;
	pcs_op_t op_in = PCS_OP_NEXT;
	logic [10:0] target_addr_in = 0, jump_target_reg_in = 0, irq_vector_in = 0;
	logic [10:0] stack_top_in, instr_pointer_out;
	logic [10:0] stack_push_addr_out, return_addr_out;
	logic stack_push_out, stack_pop_out, table_fetch_out;
	int n_errors = 0, cmp_count = 0, cyc = 0;
	always #5 mclk_in = ~mclk_in;
	pcs_program_counter #(.PC_WIDTH(11)) dut (.*);
	pcs_partner u_stk (.mclk_in(mclk_in), .push_in(stack_push_out),
		.addr_in(stack_push_addr_out), .top_out(stack_top_in));
	task step(input pcs_op_t o, input logic i, input logic [10:0] e,
		input logic [2:0] s);
		@(negedge mclk_in);
		exec_in = 1;
		op_in = o;
		irq_accept_in = i;
		@(negedge mclk_in);
		exec_in = 0;
		irq_accept_in = 0;
		cmp_count += 2;
		if (instr_pointer_out !== e)
		begin
			n_errors++;
			$display("[ERR] %0t pointer %h", $time, instr_pointer_out);
		end
		if ({stack_push_out, stack_pop_out, table_fetch_out} !== s)
		begin
			n_errors++;
			$display("[ERR] %0t strobes wrong", $time);
		end
	endtask : step
	task check_addr(input logic [10:0] got, input logic [10:0] e);
		cmp_count++;
		if (got !== e)
		begin
			n_errors++;
			$display("[ERR] %0t address %h", $time, got);
		end
	endtask : check_addr
	task t_seq;
		step(PCS_OP_NEXT, 0, 11'h001, 3'b000);
		check_addr(return_addr_out, 11'h001);
		target_addr_in = 11'h7ff;
		step(PCS_OP_JUMP, 0, 11'h7ff, 3'b000);
		step(PCS_OP_NEXT, 0, 11'h000, 3'b000);
	endtask : t_seq
	task t_branch;
		target_addr_in = 11'h005;
		step(PCS_OP_CALL, 0, 11'h005, 3'b100);
		check_addr(stack_push_addr_out, 11'h001);
		@(negedge mclk_in);
		step(PCS_OP_RETURN, 0, 11'h001, 3'b010);
		jump_target_reg_in = 11'h3ff;
		step(PCS_OP_TABLE_READ, 0, 11'h3ff, 3'b101);
		check_addr(stack_push_addr_out, 11'h002);
	endtask : t_branch
	task t_irq;
		irq_vector_in = 11'h003;
		step(PCS_OP_JUMP, 1, 11'h003, 3'b100);
		check_addr(stack_push_addr_out, 11'h3ff);
	endtask : t_irq
	task t_modes;
		jump_target_reg_in = 11'h123;
		step(PCS_OP_JUMP_IND, 0, 11'h123, 3'b000);
		step(PCS_OP_CALL_IND, 0, 11'h123, 3'b100);
		check_addr(stack_push_addr_out, 11'h124);
		@(negedge mclk_in);
		step(PCS_OP_RETURN_SKIP, 0, 11'h124, 3'b010);
		step(PCS_OP_RETURN_IRQ, 0, 11'h124, 3'b010);
	endtask : t_modes
	task t_reset;
		@(negedge mclk_in);
		rst_n_in = 0;
		exec_in = 1;
		@(negedge mclk_in);
		rst_n_in = 1;
		exec_in = 0;
		cmp_count++;
		if (instr_pointer_out !== 11'h000 || stack_pop_out !== 1'b0)
		begin
			n_errors++;
			$display("[ERR] %0t reset pointer %h", $time, instr_pointer_out);
		end
		@(negedge mclk_in);
		cmp_count++;
		if (instr_pointer_out !== 11'h000)
		begin
			n_errors++;
			$display("[ERR] %0t idle pointer %h", $time, instr_pointer_out);
		end
	endtask : t_reset
	task tally_and_finish;
		if (n_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	always @(posedge mclk_in)
	begin
		cyc++;
		if (cyc == 500)
		begin
			n_errors++;
			tally_and_finish;
		end
	end
	initial
	begin
		repeat (5) @(negedge mclk_in);
		rst_n_in = 1;
		t_seq;
		t_branch;
		t_irq;
		t_modes;
		t_reset;
		tally_and_finish;
	end
endmodule : pcs_program_counter_bench
